// file: bench/pulse_load.sv
// Load model: counts rising edges and measures the period of each pulse line.
// Assumes pulse lines are registered on pclk.
`timescale 1ns/100ps
module pulse_load (
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic [3:0]       pulse,
	output logic      [3:0][31:0] edges,
	output logic      [3:0][31:0] period
);
	logic [3:0]       prev_r;
	logic [3:0][31:0] since_r;

	// Edge count and cycles between rising edges
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prev_r  <= '0;
			edges   <= '0;
			period  <= '0;
			since_r <= '0;
		end else begin
			prev_r <= pulse;
			for (int i = 0; i < 4; i++) begin
				if (pulse[i] && !prev_r[i]) begin
					edges[i]   <= edges[i] + 32'h0000_0001;
					period[i]  <= since_r[i]; // Period seen by the load
					since_r[i] <= 32'h0000_0001;
				end else begin
					since_r[i] <= since_r[i] + 32'h0000_0001;
				end
			end
		end
	end
endmodule

// file: bench/test_pulse_train_output.sv
// Testbench of the pulse train generator: APB master, row table, hand tests.
// Assumes pulse_load beside the design and a 10 MHz pclk.
`timescale 1ns/100ps
`include "pulse_train_defs.svh"
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin fail_count++; \
	$display("mismatch %s expected %0h seen %0h", n, e, g); end end
module test_pulse_train_output;
	typedef struct packed {
		logic [1:0]  ch;
		logic [3:0]  ctrl;
		logic [15:0] freq;
		logic [31:0] pre;
		logic [2:0]  err;
	} row_t;
	logic             pclk, presetn, psel, penable, pwrite, pready, pslverr, prog_err;
	logic [11:0]      paddr;
	logic [31:0]      pwdata, prdata, rq;
	logic [3:0]       pulses, chan_done;
	logic [3:0][31:0] edges, period;
	logic             re, rr;
	int               fail_count, checked, cyc;
	logic [31:0]      snap;
	row_t             rows [8] = '{
		'{2'h0, 4'h0, 16'h0000, 32'h0000_0001, `ERR_FREQ},
		'{2'h0, 4'h0, 16'h2711, 32'h0000_0001, `ERR_FREQ},
		'{2'h1, 4'h1, 16'h0013, 32'h0000_0001, `ERR_FREQ},
		'{2'h2, 4'h0, 16'h1389, 32'h0000_0001, `ERR_FREQ},
		'{2'h0, 4'h2, 16'h03E8, 32'h0000_0000, `ERR_PRESET},
		'{2'h1, 4'h2, 16'h03E8, 32'h05F5_E101, `ERR_PRESET},
		'{2'h0, 4'h3, 16'h0014, 32'h05F5_E100, `ERR_OK},
		'{2'h3, 4'h0, 16'h1388, 32'h0000_0000, `ERR_OK}};

	pulse_train_output pulse_train_output_i (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .pulse_channel_one(pulses[0]), .pulse_channel_two(pulses[1]),
		.pulse_channel_three(pulses[2]), .pulse_channel_four(pulses[3]), .chan_done(chan_done),
		.program_error_flag(prog_err));
	pulse_load pulse_load_i (.pclk(pclk), .presetn(presetn), .pulse(pulses), .edges(edges), .period(period));

	// Clock
	always #50 pclk = ~pclk;

	// Hang guard
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			fail_count++;
			conclude();
		end
	end

	task conclude();
		if (fail_count == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// One APB transfer; response taken at the edge that sees pready high
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			rq = prdata;
			re = pslverr;
			rr = pready;
		end while (rr !== 1'b1);
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task idle(input int n);
		repeat (n) @(negedge pclk);
	endtask

	function logic [11:0] ad(input logic [1:0] c, input logic [2:0] w);
		return {5'h00, c, w, 2'b00};
	endfunction

	function logic near(input logic [31:0] v, input logic [31:0] e);
		return (v * 20 >= e * 19) && (v * 20 <= e * 21);
	endfunction

	task setup(input logic [1:0] c, input logic [15:0] f, input logic [31:0] p, input logic [3:0] ctl);
		apb(1'b1, ad(c, `W_FREQ), {16'h0000, f});
		apb(1'b1, ad(c, `W_PRE_HI), {16'h0000, p[31:16]});
		apb(1'b1, ad(c, `W_PRE_LO), {16'h0000, p[15:0]});
		apb(1'b1, ad(c, `W_CTRL), {28'h000_0000, ctl});
		idle(2);
	endtask

	// Main sequence
	initial begin
		{pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		{fail_count, checked, cyc} = '0;
		repeat (4) @(posedge pclk);
		`CHK("done_in_reset", 4'h0, chan_done)
		presetn <= 1'b1;
		apb(1'b0, ad(2'h0, `W_FREQ), 32'h0000_0000);
		`CHK("default_freq", {16'h0000, `DEF_FREQ}, rq)
		apb(1'b0, ad(2'h3, `W_PRE_LO), 32'h0000_0000);
		`CHK("default_preset", {16'h0000, `DEF_PRESET}, rq)
		apb(1'b1, ad(2'h1, `W_RSVD), 32'h0000_FFFF);
		apb(1'b0, ad(2'h1, `W_RSVD), 32'h0000_0000);
		`CHK("reserved", 32'h0000_0000, rq)
		apb(1'b0, 12'h0A0, 32'h0000_0000);
		`CHK("unmapped_err", 1'b1, re)
		// Configuration check on run rise, row per case
		foreach (rows[i]) begin
			setup(rows[i].ch, rows[i].freq, rows[i].pre, rows[i].ctrl | 4'h4);
			apb(1'b0, ad(rows[i].ch, `W_ERR), 32'h0000_0000);
			`CHK("err_code", {29'h0000_0000, rows[i].err}, rq)
			`CHK("flag", rows[i].err != `ERR_OK, prog_err)
			apb(1'b0, ad(rows[i].ch, `W_CTRL), 32'h0000_0000);
			`CHK("active", rows[i].err == `ERR_OK, rq[`S_ACTIVE])
			apb(1'b1, `ADDR_GLOBAL, 32'h0000_0001);
			apb(1'b1, ad(rows[i].ch, `W_CTRL), 32'h0000_0000);
			idle(3);
			apb(1'b0, ad(rows[i].ch, `W_CTRL), 32'h0000_0000);
			`CHK("complete", 1'b1, rq[`S_COMPLETE])
		end
		// Exact count of three pulses at the top of mode 1
		snap = edges[1];
		setup(2'h1, `FREQ_MAX, 32'h0000_0003, 4'h7);
		idle(800);
		`CHK("pulses_sent", snap + 32'h0000_0003, edges[1])
		`CHK("done_mirror", 1'b1, chan_done[1])
		apb(1'b0, ad(2'h1, `W_CNT_LO), 32'h0000_0000);
		`CHK("count", 32'h0000_0003, rq)
		apb(1'b0, ad(2'h1, `W_CTRL), 32'h0000_0000);
		`CHK("stopped", 2'b10, rq[`S_COMPLETE:`S_ACTIVE])
		`CHK("no_overflow", 1'b0, rq[`S_OVERFLOW])
		apb(1'b1, ad(2'h1, `W_CTRL), 32'h0000_0003);
		idle(3);
		`CHK("done_low", 1'b0, chan_done[1])
		// Free running, rate change, defaults load around run
		setup(2'h0, `FREQ_MAX, 32'h0000_0000, 4'h5);
		idle(400);
		`CHK("period_100k", 1'b1, near(period[0], 32'h0000_0064))
		apb(1'b1, ad(2'h0, `W_FREQ), 32'h0000_1388);
		idle(1000); // Rate changes kept far apart
		`CHK("period_50k", 1'b1, near(period[0], 32'h0000_00C8))
		apb(1'b1, ad(2'h0, `W_CTRL), 32'h0000_000D);
		idle(3);
		apb(1'b0, ad(2'h0, `W_FREQ), 32'h0000_0000);
		`CHK("ini_ignored", 32'h0000_1388, rq)
		apb(1'b0, ad(2'h0, `W_CNT_LO), 32'h0000_0000);
		`CHK("count_moves", 1'b1, rq > 32'h0000_0005)
		apb(1'b1, ad(2'h0, `W_CTRL), 32'h0000_0008);
		idle(3);
		snap = edges[0];
		apb(1'b0, ad(2'h0, `W_FREQ), 32'h0000_0000);
		`CHK("ini_reload", {16'h0000, `DEF_FREQ}, rq)
		apb(1'b0, ad(2'h0, `W_CTRL), 32'h0000_0000);
		`CHK("run_fall", 2'b10, rq[`S_COMPLETE:`S_ACTIVE])
		idle(300);
		`CHK("no_pulses", snap, edges[0])
		apb(1'b1, ad(2'h0, `W_CTRL), 32'h0000_0000);
		// Mode 0 ranges on channels one and three
		setup(2'h0, `FREQ_MAX, 32'h0000_0000, 4'h4);
		setup(2'h2, `FREQ_MAX_LO, 32'h0000_0000, 4'h4);
		idle(5000);
		`CHK("period_10k", 1'b1, near(period[0], 32'h0000_03E8))
		`CHK("period_5k", 1'b1, near(period[2], 32'h0000_07D0))
		apb(1'b1, ad(2'h2, `W_CTRL), 32'h0000_0000);
		apb(1'b1, ad(2'h0, `W_CTRL), 32'h0000_0000);
		idle(3);
		// Preset lowered under the count
		setup(2'h0, `FREQ_MAX, 32'h0000_03E8, 4'h7);
		idle(400);
		apb(1'b1, ad(2'h0, `W_PRE_LO), 32'h0000_0001);
		idle(200);
		apb(1'b0, ad(2'h0, `W_CTRL), 32'h0000_0000);
		`CHK("overflow", 1'b1, rq[`S_OVERFLOW])
		apb(1'b1, ad(2'h0, `W_CTRL), 32'h0000_0000);
		conclude();
	end
endmodule

// file: common/cfg_bus_if.sv
// Link between the generator core and its configuration store.
// Core writes and addresses; store returns read data and live settings.
`timescale 1ns/100ps
interface cfg_bus_if;
	logic             we;
	logic [1:0]       wch;
	logic [2:0]       wword;
	logic [15:0]      wdata;
	logic [1:0]       rch;
	logic [2:0]       rword;
	logic [15:0]      rdata;
	logic [3:0]       reload;
	logic [3:0][15:0] freq;
	logic [3:0][31:0] preset;

	modport core (output we, wch, wword, wdata, rch, rword, reload, input rdata, freq, preset);
	modport store (input we, wch, wword, wdata, rch, rword, reload, output rdata, freq, preset);
endinterface

// file: common/pulse_train_defs.svh
// Constants of the pulse train generator: offsets, fields, ranges, defaults.
// Assumes a 10 MHz pclk; one clock is one scan.
`ifndef PULSE_TRAIN_DEFS_SVH
`define PULSE_TRAIN_DEFS_SVH

// Clock rate and output frequency limits
`define CLK_HZ       24'h98_9680
`define FREQ_MIN     16'h0001
`define FREQ_MAX     16'h2710
`define FREQ_MIN_M1  16'h0014
`define FREQ_MAX_LO  16'h1388
`define M1_STEP_MUL  24'h00_0014
`define PRESET_MIN   32'h0000_0001
`define PRESET_MAX   32'h05F5_E100

// Error codes
`define ERR_OK       3'h0
`define ERR_FREQ     3'h2
`define ERR_PRESET   3'h4

// Control word indices within a channel
`define W_FREQ       3'h0
`define W_RSVD       3'h1
`define W_PRE_HI     3'h2
`define W_PRE_LO     3'h3
`define W_CNT_HI     3'h4
`define W_CNT_LO     3'h5
`define W_ERR        3'h6
`define W_CTRL       3'h7

// Channel control word fields
`define C_MODE       0
`define C_CNT_EN     1
`define C_RUN        2
`define C_INI        3
`define S_ACTIVE     8
`define S_COMPLETE   9
`define S_OVERFLOW   10

// Global word holding the program error flag
`define ADDR_GLOBAL  12'h080
`define G_PROG_ERR   0

// Defaults reloaded by the defaults load input
`define DEF_FREQ     16'h03E8
`define DEF_PRESET   32'h0000_03E8

`endif

// file: common/pulse_train_pkg.sv
// Types of the pulse train generator.
// Constants live in pulse_train_defs.svh.
package pulse_train_pkg;

	// Channel run state, Gray along idle, run, done
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_RUN  = 2'b01,
		ST_DONE = 2'b11
	} run_state_t;

	// State of one output channel
	typedef struct packed {
		run_state_t  st;
		logic        mode;
		logic        cnt_en;
		logic        run;
		logic        defaults_load_input;
		logic        run_q;
		logic        active;
		logic        complete;
		logic        overflow;
		logic        pulse;
		logic [31:0] count;
		logic [23:0] acc;
		logic [2:0]  err;
	} ch_state_t;

	// State of the whole generator
	typedef struct packed {
		ch_state_t [3:0] ch;
		logic [31:0]     rdata;
		logic            rd_mem;
		logic            prog_err;
	} top_state_t;

	// State of the configuration store
	typedef struct packed {
		logic [3:0][15:0] freq;
		logic [3:0][31:0] preset;
		logic [15:0]      rdata;
	} store_state_t;

endpackage

// file: rtl/cfg_store.sv
// Configuration store: frequency and preset words of four channels.
// Assumes writes and reloads come from the core on pclk; read data registered.
`timescale 1ns/100ps
`include "pulse_train_defs.svh"
module cfg_store (
	input  wire logic pclk,
	input  wire logic presetn,
	cfg_bus_if.store  bus
);
	pulse_train_pkg::store_state_t r;
	pulse_train_pkg::store_state_t r_nxt;

	// Writes, default reloads and registered read
	always_comb begin
		r_nxt = r;
		if (bus.we) begin
			if (bus.wword == `W_FREQ) begin
				r_nxt.freq[bus.wch] = bus.wdata;
			end else if (bus.wword == `W_PRE_HI) begin
				r_nxt.preset[bus.wch][31:16] = bus.wdata;
			end else if (bus.wword == `W_PRE_LO) begin
				r_nxt.preset[bus.wch][15:0] = bus.wdata;
			end
		end
		for (int i = 0; i < 4; i++) begin
			if (bus.reload[i]) begin
				r_nxt.freq[i]   = `DEF_FREQ;
				r_nxt.preset[i] = `DEF_PRESET;
			end
		end
		if (bus.rword == `W_FREQ) begin
			r_nxt.rdata = r.freq[bus.rch];
		end else if (bus.rword == `W_PRE_HI) begin
			r_nxt.rdata = r.preset[bus.rch][31:16];
		end else if (bus.rword == `W_PRE_LO) begin
			r_nxt.rdata = r.preset[bus.rch][15:0];
		end else begin
			r_nxt.rdata = 16'h0000;
		end
	end

	// State register with defaults at reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r <= '{freq: {4{`DEF_FREQ}}, preset: {4{`DEF_PRESET}}, rdata: 16'h0000};
		end else begin
			r <= r_nxt;
		end
	end

	assign bus.rdata  = r.rdata;
	assign bus.freq   = r.freq;
	assign bus.preset = r.preset;
endmodule

// file: rtl/pulse_train_output.sv
// Four-channel pulse train generator with APB register access.
// Assumes an APB master on pclk (10 MHz); each clock counts as one scan.
// Overview of operation
// - Channels one, two mode 0: 1 Hz-10 kHz
// - Channels one, two mode 1: 200 Hz-100 kHz
// - Channels three, four: mode 0, 1 Hz-5 kHz
// - Output frequency within five percent
// - Counting off: pulse while run asserted
// - Counting on: exact preset count, channels one, two
// - Stop when count reaches 32-bit preset
// - Current count refreshed every scan
// - Check configuration on run rise, flag errors
// - Frequency out of range gives code 2
// - Preset out of range code 4, valid 0
// - Run rise sets active, starts pulses
// - Frequency rewrite takes effect without restart
// - Run fall stops, clears active, sets complete
// - Defaults load ignored while run asserted
// - Eight control words per channel
// - Complete set when done, cleared while pulsing
// - Overflow when pulse exceeds preset
// - Done mirrors complete, low without run
`timescale 1ns/100ps
`include "pulse_train_defs.svh"
module pulse_train_output (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic [11:0] paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             pulse_channel_one,
	output logic             pulse_channel_two,
	output logic             pulse_channel_three,
	output logic             pulse_channel_four,
	output logic      [3:0]  chan_done,
	output logic             program_error_flag
);
	pulse_train_pkg::top_state_t r;
	pulse_train_pkg::top_state_t r_nxt;
	cfg_bus_if                   cfg ();

	// Address decode: channel words or the global word
	function automatic logic addr_ok(input logic [11:0] a);
		if (a[1:0] != 2'b00) begin
			return 1'b0;
		end else if (a[11:7] == 5'h00) begin
			return 1'b1;
		end else if (a == `ADDR_GLOBAL) begin
			return 1'b1;
		end else begin
			return 1'b0;
		end
	endfunction

	// Configuration check for one channel
	function automatic logic [2:0] cfg_check(input logic hi_ch, input logic mode, input logic cnt_en,
		input logic [15:0] f, input logic [31:0] pre);
		logic f_bad;
		f_bad = hi_ch ? (f < `FREQ_MIN || f > `FREQ_MAX_LO)
			: (mode ? (f < `FREQ_MIN_M1 || f > `FREQ_MAX) : (f < `FREQ_MIN || f > `FREQ_MAX));
		if (f_bad) begin
			return `ERR_FREQ;
		end else if (cnt_en && (pre < `PRESET_MIN || pre > `PRESET_MAX)) begin
			return `ERR_PRESET;
		end else begin
			return `ERR_OK;
		end
	endfunction

	// Accumulator step: twice the frequency in Hz, one toggle per overflow
	function automatic logic [23:0] nco_step(input logic mode, input logic [15:0] f);
		return mode ? {8'h00, f} * `M1_STEP_MUL : {7'h00, f, 1'b0};
	endfunction

	logic        acc_wr;
	logic        setup;
	logic        is_glob;
	logic [1:0]  a_ch;
	logic [2:0]  a_word;

	// Bus phase and address fields
	assign setup   = psel && !penable;
	assign acc_wr  = psel && penable && pwrite && addr_ok(paddr);
	assign is_glob = (paddr == `ADDR_GLOBAL);
	assign a_ch    = paddr[6:5];
	assign a_word  = paddr[4:2];

	// Store side of the configuration link
	assign cfg.we     = acc_wr && !is_glob;
	assign cfg.wch    = a_ch;
	assign cfg.wword  = a_word;
	assign cfg.wdata  = pwdata[15:0];
	assign cfg.rch    = a_ch;
	assign cfg.rword  = a_word;
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			cfg.reload[i] = r.ch[i].defaults_load_input && !r.ch[i].run;
		end
	end

	// Next state of channels and bus slave
	always_comb begin
		logic [23:0] sum;
		logic [2:0]  chk;
		logic        rise;
		logic        fall;
		logic        err_set;
		sum     = 24'h00_0000;
		chk     = `ERR_OK;
		rise    = 1'b0;
		fall    = 1'b0;
		err_set = 1'b0;
		r_nxt   = r;
		for (int i = 0; i < 4; i++) begin
			// Control word write
			if (acc_wr && !is_glob && a_ch == 2'(i) && a_word == `W_CTRL) begin
				r_nxt.ch[i].mode   = (i < 2) && pwdata[`C_MODE];
				r_nxt.ch[i].cnt_en = (i < 2) && pwdata[`C_CNT_EN];
				r_nxt.ch[i].run    = pwdata[`C_RUN];
				r_nxt.ch[i].defaults_load_input    = pwdata[`C_INI];
			end
			r_nxt.ch[i].run_q = r.ch[i].run;
			rise = r.ch[i].run && !r.ch[i].run_q;
			fall = !r.ch[i].run && r.ch[i].run_q;
			if (rise) begin
				chk = cfg_check(i >= 2, r.ch[i].mode, r.ch[i].cnt_en, cfg.freq[i], cfg.preset[i]);
				r_nxt.ch[i].err = chk;
				if (chk != `ERR_OK) begin
					err_set = 1'b1;
				end else begin
					r_nxt.ch[i].st       = pulse_train_pkg::ST_RUN;
					r_nxt.ch[i].active   = 1'b1;
					r_nxt.ch[i].complete = 1'b0;
					r_nxt.ch[i].overflow = 1'b0;
					r_nxt.ch[i].count    = 32'h0000_0000;
					r_nxt.ch[i].acc      = 24'h00_0000;
					r_nxt.ch[i].pulse    = 1'b0;
				end
			end else if (fall) begin
				r_nxt.ch[i].st       = pulse_train_pkg::ST_DONE;
				r_nxt.ch[i].active   = 1'b0;
				r_nxt.ch[i].complete = 1'b1;
				r_nxt.ch[i].pulse    = 1'b0;
			end else if (r.ch[i].st == pulse_train_pkg::ST_RUN) begin
				// Live frequency, so rewrites apply at once
				sum = r.ch[i].acc + nco_step(r.ch[i].mode, cfg.freq[i]);
				if (sum >= `CLK_HZ) begin
					r_nxt.ch[i].acc   = sum - `CLK_HZ;
					r_nxt.ch[i].pulse = !r.ch[i].pulse;
					if (!r.ch[i].pulse) begin
						r_nxt.ch[i].count = r.ch[i].count + 32'h0000_0001;
						if (r.ch[i].cnt_en && r.ch[i].count >= cfg.preset[i]) begin
							r_nxt.ch[i].overflow = 1'b1;
						end
					end else if (r.ch[i].cnt_en && r.ch[i].count >= cfg.preset[i]) begin
						r_nxt.ch[i].st       = pulse_train_pkg::ST_DONE;
						r_nxt.ch[i].active   = 1'b0;
						r_nxt.ch[i].complete = 1'b1;
					end
				end else begin
					r_nxt.ch[i].acc = sum;
				end
			end
		end
		// Program error flag: write one clears, a new error wins
		if (acc_wr && is_glob && pwdata[`G_PROG_ERR]) begin
			r_nxt.prog_err = 1'b0;
		end
		if (err_set) begin
			r_nxt.prog_err = 1'b1;
		end
		// Read data captured in the setup phase
		if (setup) begin
			r_nxt.rd_mem = 1'b0;
			r_nxt.rdata  = 32'h0000_0000;
			if (!addr_ok(paddr)) begin
				r_nxt.rdata = 32'h0000_0000;
			end else if (is_glob) begin
				r_nxt.rdata = {31'h0000_0000, r.prog_err};
			end else if (a_word == `W_FREQ || a_word == `W_PRE_HI || a_word == `W_PRE_LO) begin
				r_nxt.rd_mem = 1'b1;
			end else if (a_word == `W_CNT_HI) begin
				r_nxt.rdata = {16'h0000, r.ch[a_ch].count[31:16]};
			end else if (a_word == `W_CNT_LO) begin
				r_nxt.rdata = {16'h0000, r.ch[a_ch].count[15:0]};
			end else if (a_word == `W_ERR) begin
				r_nxt.rdata = {29'h0000_0000, r.ch[a_ch].err};
			end else if (a_word == `W_CTRL) begin
				r_nxt.rdata = {21'h00_0000, r.ch[a_ch].overflow, r.ch[a_ch].complete, r.ch[a_ch].active,
					4'h0, r.ch[a_ch].defaults_load_input, r.ch[a_ch].run, r.ch[a_ch].cnt_en, r.ch[a_ch].mode};
			end
		end
	end

	// State register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r <= '0;
		end else begin
			r <= r_nxt;
		end
	end

	cfg_store u_store (
		.pclk    (pclk),
		.presetn (presetn),
		.bus     (cfg.store)
	);

	// Bus answers and pin outputs
	assign pready              = 1'b1;
	assign pslverr             = psel && penable && !addr_ok(paddr);
	assign prdata              = r.rd_mem ? {16'h0000, cfg.rdata} : r.rdata;
	assign pulse_channel_one   = r.ch[0].pulse;
	assign pulse_channel_two   = r.ch[1].pulse;
	assign pulse_channel_three = r.ch[2].pulse;
	assign pulse_channel_four  = r.ch[3].pulse;
	assign program_error_flag  = r.prog_err;
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			chan_done[i] = r.ch[i].complete && r.ch[i].run;
		end
	end

	// Helper: cycles since the last toggle of channel one
	logic [15:0] half_cnt;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			half_cnt <= 16'h0000;
		end else if (r.ch[0].st != pulse_train_pkg::ST_RUN || r_nxt.ch[0].pulse != r.ch[0].pulse) begin
			half_cnt <= 16'h0000;
		end else begin
			half_cnt <= half_cnt + 16'h0001;
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	chk_freq_range_m1: assert property ($rose(r.ch[1].run) && r.ch[1].mode && cfg.freq[1] < `FREQ_MIN_M1
		|=> r.ch[1].err == `ERR_FREQ && r.prog_err && r.ch[1].st != pulse_train_pkg::ST_RUN)
		else $error("frequency error not raised");
	chk_preset_range: assert property ($rose(r.ch[0].run) && r.ch[0].cnt_en && !r.ch[0].mode
		&& cfg.freq[0] == `DEF_FREQ && (cfg.preset[0] < `PRESET_MIN || cfg.preset[0] > `PRESET_MAX)
		|=> r.ch[0].err == `ERR_PRESET)
		else $error("preset error not raised");
	chk_start_active: assert property ($rose(r.ch[0].run) && !r.ch[0].mode && !r.ch[0].cnt_en
		&& cfg.freq[0] >= `FREQ_MIN && cfg.freq[0] <= `FREQ_MAX
		|=> r.ch[0].active && !r.ch[0].complete && r.ch[0].err == `ERR_OK)
		else $error("output did not start");
	chk_stop_complete: assert property ($fell(r.ch[1].run) |=> !r.ch[1].active && r.ch[1].complete
		&& !pulse_channel_two)
		else $error("stop did not complete");
	chk_done_gated: assert property (!r.ch[0].run |-> !chan_done[0])
		else $error("done high without run");
	chk_count_stop: assert property (r.ch[0].st == pulse_train_pkg::ST_RUN && r.ch[0].run && r.ch[0].cnt_en
		&& r.ch[0].pulse && !r_nxt.ch[0].pulse && r.ch[0].count >= cfg.preset[0]
		|=> r.ch[0].st == pulse_train_pkg::ST_DONE && r.ch[0].complete && !r.ch[0].active)
		else $error("preset reached but output runs");
	chk_ini_blocked: assert property (r.ch[2].run |-> !cfg.reload[2])
		else $error("defaults reloaded while running");
	chk_upper_mode0: assert property (!r.ch[2].mode && !r.ch[3].mode && !r.ch[2].cnt_en && !r.ch[3].cnt_en)
		else $error("channels three and four left mode 0");
	chk_half_period: assert property (r.ch[0].st == pulse_train_pkg::ST_RUN && r.ch[0].mode
		&& cfg.freq[0] == `FREQ_MAX && $stable(cfg.freq[0]) && r_nxt.ch[0].pulse != r.ch[0].pulse && r.ch[0].run
		|-> half_cnt >= 16'h0030 && half_cnt <= 16'h0034)
		else $error("half period off at full rate");
	chk_count_start: assert property ($rose(r.ch[0].active) |-> r.ch[0].count == 32'h0000_0000
		##1 r.ch[0].count <= 32'h0000_0001)
		else $error("count not cleared at start");

	cov_start_one: cover property ($rose(r.ch[0].active));
	cov_preset_done: cover property (r.ch[0].cnt_en && $rose(r.ch[0].complete) && r.ch[0].run);
	cov_error: cover property ($rose(r.prog_err));
	cov_mode1_run: cover property (r.ch[1].mode && r.ch[1].st == pulse_train_pkg::ST_RUN && $changed(r.ch[1].pulse));
endmodule
